// *** common/hssb_defines.vh ***
// register map, status fields and bus answers of the single-step and breakpoint unit
`ifndef HSSB_DEFINES_VH
`define HSSB_DEFINES_VH

// register indices, byte address is four times the index
`define HSSB_IDX_W          4
`define HSSB_IDX_LOW        4'h0
`define HSSB_IDX_HIGH       4'h1
`define HSSB_IDX_ARM        4'h2
`define HSSB_IDX_STATUS     4'h3
`define HSSB_IDX_STEPS      4'h4
`define HSSB_IDX_HELD       4'h5
`define HSSB_AXI_AW         6
`define HSSB_IDX_LSB        2

// status register fields
`define HSSB_ST_EN_BIT      0
`define HSSB_ST_EVERY_BIT   1
`define HSSB_ST_ARMED_BIT   2
`define HSSB_ST_HOLD_BIT    3

// button positions in the debug button bank
`define HSSB_BTN_COUNT      4
`define HSSB_BTN_ENABLE     0
`define HSSB_BTN_EVERY      1
`define HSSB_BTN_OPCODE     2
`define HSSB_BTN_ADVANCE    3

// axi answers
`define HSSB_RESP_OKAY      2'h0
`define HSSB_RESP_SLVERR    2'h2

`endif

// *** src/hssb_button.v ***
// one debug button: two-flop synchroniser and press edge detector
`timescale 1ns/10ps
module hssb_button (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  input  wire ce,
  // button pin, active high while pressed
  input  wire pin,
  // one-cycle pulse per press
  output reg  press_q
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // the board debounces with an rc network, so only the edge is taken here
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      prev_q  <= 1'b0;
      press_q <= 1'b0;
    end else if (ce) begin
      meta_q  <= pin;
      sync_q  <= meta_q;
      prev_q  <= sync_q;
      press_q <= sync_q & ~prev_q;
    end
  end

endmodule

// *** src/hssb_match.v ***
// breakpoint comparator: full sixteen-bit address against the two latched bytes
`timescale 1ns/10ps
module hssb_match #(
  parameter AW = 16
) (
  // clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          ce,
  // bus cycle to check
  input  wire          check,
  input  wire [AW-1:0] addr,
  // loaded target and arming state
  input  wire [AW-1:0] target,
  input  wire          armed,
  // one-cycle match pulse
  output reg           match_q
);

  // no cycle-type qualifier: fetches, data and rom addresses all compare
  always @(posedge aclk) begin
    if (!aresetn) begin
      match_q <= 1'b0;
    end else if (ce) begin
      match_q <= check & armed & (addr == target);
    end
  end

endmodule

// *** src/hssb_top.v ***
// hardware single stepper with sixteen-bit breakpoint, registers over axi4-lite
//
// Operation
// - stepping comes up disabled after power-up
// - enable button toggles stepping at any time (here a breakpoint match in the same cycle wins and the press is lost)
// - every-cycle mode holds fetches and memory writes
// - opcode mode holds only opcode fetch cycles
// - only power-on reset clears stepper state
// - stop the processor with wait states
// - processor idle between steps while enabled
// - each advance press releases one held cycle
// - every-cycle mode also holds operand fetches
// - target address in two eight-bit latches
// - low byte at 00, high at 01
// - access to 02 arms the comparator (here only a write arms it, a read does not)
// - armed comparator checks every bus access
// - compare whole address space, not opcodes only
// - match turns stepping on at once
// - match disarms; rearm needs another access
// - disabling stepping resumes full speed
// - indicator lit while stepping is enabled
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "hssb_defines.vh"
module hssb_top #(
  parameter AW = 16,
  parameter SW = 16
) (
  // clock, power-on reset, clock enable
  input  wire                     aclk,
  input  wire                     aresetn,
  input  wire                     ce,
  // axi4-lite write address
  input  wire                     s_axi_awvalid,
  output wire                     s_axi_awready,
  input  wire [`HSSB_AXI_AW-1:0]  s_axi_awaddr,
  input  wire [2:0]               s_axi_awprot,
  // axi4-lite write data
  input  wire                     s_axi_wvalid,
  output wire                     s_axi_wready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  // axi4-lite write response
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  output reg  [1:0]               s_axi_bresp,
  // axi4-lite read address
  input  wire                     s_axi_arvalid,
  output wire                     s_axi_arready,
  input  wire [`HSSB_AXI_AW-1:0]  s_axi_araddr,
  input  wire [2:0]               s_axi_arprot,
  // axi4-lite read data
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  output reg  [31:0]              s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  // debug button bank, active high while pressed
  input  wire                     step_enable_button,
  input  wire                     every_cycle_mode_button,
  input  wire                     opcode_fetch_mode_button,
  input  wire                     step_advance_button,
  // processor bus, from pins
  input  wire                     cpu_ale,
  input  wire [AW-1:0]            cpu_addr,
  input  wire                     cpu_opfetch,
  input  wire                     cpu_mem_rd,
  input  wire                     cpu_mem_wr,
  // processor wait-state input, high lets the cycle finish
  output reg                      cpu_ready,
  // indicator
  output wire                     step_enabled_led
);

  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_HOLD = 2'h1;
  localparam [1:0] ST_STEP = 2'h2;
  localparam       PW      = 4 + AW;

  // ---------------- buttons ----------------
  wire [`HSSB_BTN_COUNT-1:0] btn_pin;
  wire [`HSSB_BTN_COUNT-1:0] btn_press;

  assign btn_pin[`HSSB_BTN_ENABLE]  = step_enable_button;
  assign btn_pin[`HSSB_BTN_EVERY]   = every_cycle_mode_button;
  assign btn_pin[`HSSB_BTN_OPCODE]  = opcode_fetch_mode_button;
  assign btn_pin[`HSSB_BTN_ADVANCE] = step_advance_button;

  genvar gi;
  generate
    for (gi = 0; gi < `HSSB_BTN_COUNT; gi = gi + 1) begin : g_btn
      hssb_button u_btn (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin     (btn_pin[gi]),
        .press_q (btn_press[gi])
      );
    end
  endgenerate

  wire press_enable  = btn_press[`HSSB_BTN_ENABLE];
  wire press_every   = btn_press[`HSSB_BTN_EVERY];
  wire press_opcode  = btn_press[`HSSB_BTN_OPCODE];
  wire press_advance = btn_press[`HSSB_BTN_ADVANCE];

  // ---------------- processor bus synchroniser ----------------
  wire [PW-1:0] pins_raw = {cpu_ale, cpu_opfetch, cpu_mem_rd, cpu_mem_wr, cpu_addr};
  reg  [PW-1:0] pins_meta_q;
  reg  [PW-1:0] pins_sync_q;
  reg           ale_prev_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pins_meta_q <= {PW{1'b0}};
      pins_sync_q <= {PW{1'b0}};
      ale_prev_q  <= 1'b0;
    end else if (ce) begin
      pins_meta_q <= pins_raw;
      pins_sync_q <= pins_meta_q;
      ale_prev_q  <= pins_sync_q[PW-1];
    end
  end

  wire          sync_ale   = pins_sync_q[PW-1];
  wire          sync_op    = pins_sync_q[PW-2];
  wire          sync_rd    = pins_sync_q[PW-3];
  wire          sync_wr    = pins_sync_q[PW-4];
  wire [AW-1:0] sync_addr  = pins_sync_q[AW-1:0];
  wire          cyc_start  = sync_ale & ~ale_prev_q;

  // cycle seen at its start, decided one clock later beside the match pulse
  reg           cyc_q;
  reg           cyc_op_q;
  reg           cyc_mem_q;
  reg  [AW-1:0] cyc_addr_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cyc_q      <= 1'b0;
      cyc_op_q   <= 1'b0;
      cyc_mem_q  <= 1'b0;
      cyc_addr_q <= {AW{1'b0}};
    end else if (ce) begin
      cyc_q <= cyc_start;
      if (cyc_start) begin
        cyc_op_q   <= sync_op;
        cyc_mem_q  <= sync_op | sync_rd | sync_wr;
        cyc_addr_q <= sync_addr;
      end
    end
  end

  // ---------------- breakpoint ----------------
  reg  [7:0]    brk_low_q;
  reg  [7:0]    brk_high_q;
  reg           armed_q;
  wire          match;
  wire          arm_write;

  hssb_match #(
    .AW (AW)
  ) u_match (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .check   (cyc_start),
    .addr    (sync_addr),
    .target  ({brk_high_q, brk_low_q}),
    .armed   (armed_q),
    .match_q (match)
  );

  // a fresh arm access in the match cycle wins, so it is never lost
  always @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
    end else if (ce) begin
      if (arm_write) begin
        armed_q <= 1'b1;
      end else if (match) begin
        armed_q <= 1'b0;
      end
    end
  end

  // ---------------- stepper control ----------------
  // aresetn is the power-on reset; the processor reset never reaches here
  reg           step_en_q;
  reg           every_q;
  reg  [1:0]    state_q;
  reg  [1:0]    state_d;
  reg           ready_d;
  reg  [SW-1:0] steps_q;
  reg  [AW-1:0] held_addr_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      step_en_q <= 1'b0;
      every_q   <= 1'b0;
    end else if (ce) begin
      if (match) begin
        step_en_q <= 1'b1;
      end else if (press_enable) begin
        step_en_q <= ~step_en_q;
      end
      if (press_every) begin
        every_q <= 1'b1;
      end else if (press_opcode) begin
        every_q <= 1'b0;
      end
    end
  end

  // the match counts as enabled in its own cycle so that very cycle is held when the mode selects it
  wire step_on  = step_en_q | match;
  wire selected = every_q ? cyc_mem_q : cyc_op_q;

  always @* begin
    state_d = state_q;
    ready_d = 1'b1;
    case (state_q)
      ST_RUN: begin
        if (cyc_q && step_on && selected) begin
          state_d = ST_HOLD;
          ready_d = 1'b0;
        end
      end
      ST_HOLD: begin
        if (!step_en_q) begin
          state_d = ST_RUN;
        end else if (press_advance) begin
          state_d = ST_STEP;
        end else begin
          ready_d = 1'b0;
        end
      end
      ST_STEP: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ready comes from a flop; the hold starts a few clocks into the cycle,
  // so the processor must sample ready no earlier than that
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= ST_RUN;
      cpu_ready   <= 1'b1;
      steps_q     <= {SW{1'b0}};
      held_addr_q <= {AW{1'b0}};
    end else if (ce) begin
      state_q   <= state_d;
      cpu_ready <= ready_d;
      if (state_q == ST_RUN && state_d == ST_HOLD) begin
        held_addr_q <= cyc_addr_q;
      end
      if (state_d == ST_STEP) begin
        steps_q <= steps_q + {{(SW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign step_enabled_led = step_en_q;

  // ---------------- axi4-lite write ----------------
  reg                    aw_have_q;
  reg [`HSSB_IDX_W-1:0]  aw_idx_q;
  reg                    w_have_q;
  reg [7:0]              w_byte_q;
  reg                    w_lane_q;

  assign s_axi_awready = ce & ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~w_have_q & ~s_axi_bvalid;

  wire wr_go   = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire wr_low  = aw_idx_q == `HSSB_IDX_LOW;
  wire wr_high = aw_idx_q == `HSSB_IDX_HIGH;
  wire wr_arm  = aw_idx_q == `HSSB_IDX_ARM;
  wire wr_map  = wr_low | wr_high | wr_arm;

  // arming is a write to the location; its data does not matter
  assign arm_write = ce & wr_go & wr_arm;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      aw_idx_q     <= {`HSSB_IDX_W{1'b0}};
      w_have_q     <= 1'b0;
      w_byte_q     <= 8'h00;
      w_lane_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HSSB_RESP_OKAY;
      brk_low_q    <= 8'h00;
      brk_high_q   <= 8'h00;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[`HSSB_AXI_AW-1:`HSSB_IDX_LSB];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `HSSB_RESP_OKAY : `HSSB_RESP_SLVERR;
        if (wr_low && w_lane_q) begin
          brk_low_q <= w_byte_q;
        end
        if (wr_high && w_lane_q) begin
          brk_high_q <= w_byte_q;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- axi4-lite read ----------------
  // the latches are write-only and read as zero; status shows live state
  wire [`HSSB_IDX_W-1:0] ar_idx = s_axi_araddr[`HSSB_AXI_AW-1:`HSSB_IDX_LSB];
  reg  [31:0]            rd_word;
  reg                    rd_map;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_map  = 1'b1;
    case (ar_idx)
      `HSSB_IDX_LOW, `HSSB_IDX_HIGH, `HSSB_IDX_ARM: begin
        rd_word = 32'h0000_0000;
      end
      `HSSB_IDX_STATUS: begin
        rd_word[`HSSB_ST_EN_BIT]    = step_en_q;
        rd_word[`HSSB_ST_EVERY_BIT] = every_q;
        rd_word[`HSSB_ST_ARMED_BIT] = armed_q;
        rd_word[`HSSB_ST_HOLD_BIT]  = state_q == ST_HOLD;
      end
      `HSSB_IDX_STEPS: begin
        rd_word[SW-1:0] = steps_q;
      end
      `HSSB_IDX_HELD: begin
        rd_word[AW-1:0] = held_addr_q;
      end
      default: begin
        rd_map = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ce & ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `HSSB_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_map ? `HSSB_RESP_OKAY : `HSSB_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** sim/hssb_top_sva.sv ***
// port checker of the single-step and breakpoint unit
`timescale 1ns/10ps
module hssb_top_sva #(
  parameter AW = 16,
  parameter SW = 16
) (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       ce,
  // register bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // buttons and processor bus
  input wire logic       step_enable_button,
  input wire logic       step_advance_button,
  input wire logic       cpu_ale,
  input wire logic       cpu_opfetch,
  input wire logic       cpu_mem_rd,
  input wire logic       cpu_mem_wr,
  input wire logic       cpu_ready,
  input wire logic       step_enabled_led
);
  default clocking cb @(posedge aclk); endclocking
  // a frozen clock enable cancels every check in progress below
  default disable iff (!aresetn || !ce);

  AST_PWRUP_FREE: assert property ($rose(aresetn) |-> !step_enabled_led && cpu_ready)
    else $error("stepping not off after power-on reset");
  AST_EN_TOGGLE: assert property ($rose(step_enable_button)
    |-> ##[3:5] (step_enabled_led != $past(step_enabled_led)))
    else $error("enable press did not toggle stepping");
  AST_FETCH_HOLD: assert property ($rose(cpu_ale) && step_enabled_led && cpu_opfetch
    |-> ##[4:6] !cpu_ready)
    else $error("opcode fetch not held while stepping");
  AST_IO_PASS: assert property ($rose(cpu_ale) && !cpu_opfetch && !cpu_mem_rd && !cpu_mem_wr
    |-> cpu_ready [*8])
    else $error("unselected cycle got wait states");
  AST_HELD_IDLE: assert property (!cpu_ready && !step_advance_button && !step_enable_button
    |=> !cpu_ready)
    else $error("held cycle released without a press");
  AST_ADV_RELEASE: assert property (!cpu_ready && $rose(step_advance_button)
    |-> ##[3:5] cpu_ready)
    else $error("advance press did not release held cycle");
  AST_ONE_STEP: assert property ($rose(cpu_ready) && step_enabled_led |-> cpu_ready [*4])
    else $error("more than one step released");
  AST_DIS_RUN: assert property ($fell(step_enabled_led) |-> ##[0:1] cpu_ready)
    else $error("disabling did not resume full speed");
  AST_LED_HOLD: assert property ($fell(cpu_ready) |-> step_enabled_led)
    else $error("wait state without indicator");
  // both halves are stored first, so the answer comes one clock after that
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

  COV_HOLD: cover property ($fell(cpu_ready));
  COV_ENABLE: cover property ($rose(step_enabled_led));
  COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind hssb_top hssb_top_sva #(.AW(AW), .SW(SW)) i_hssb_top_sva (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .step_enable_button, .step_advance_button, .cpu_ale, .cpu_opfetch, .cpu_mem_rd,
  .cpu_mem_wr, .cpu_ready, .step_enabled_led
);

// *** sim/hssb_cpu_model.sv ***
// processor bus model: one bus cycle at a time, stretched by the ready input
`timescale 1ns/10ps
module hssb_cpu_model (
  // clock and wait-state input
  input  wire logic        aclk,
  input  wire logic        cpu_ready,
  // bus outputs
  output logic             cpu_ale = 1'h0,
  output logic [15:0]      cpu_addr = 16'h0,
  output logic             cpu_opfetch = 1'h0,
  output logic             cpu_mem_rd = 1'h0,
  output logic             cpu_mem_wr = 1'h0
);
  // kind 0 opcode fetch, 1 memory read, 2 memory write, 3 io
  task automatic bus_cycle(input logic [15:0] a, input int k, output int waited);
    @(posedge aclk);
    cpu_addr <= a;
    cpu_opfetch <= (k == 0);
    cpu_mem_rd <= (k == 1);
    cpu_mem_wr <= (k == 2);
    @(posedge aclk);
    cpu_ale <= 1'h1;
    // the unit decides late, so ready is only looked at after its decision
    repeat (8) @(posedge aclk);
    waited = 0;
    while (cpu_ready !== 1'h1) begin
      waited++;
      @(posedge aclk);
    end
    cpu_ale <= 1'h0;
    @(posedge aclk);
    // one clock after ale falls the released bus shows the inverted address, not the old one
    cpu_addr <= ~a;
    cpu_opfetch <= 1'h0;
    cpu_mem_rd <= 1'h0;
    cpu_mem_wr <= 1'h0;
  endtask
endmodule

// *** sim/hw_single_step_breakpoint_bench.sv ***
// self-checking bench of the single-step and breakpoint unit
`timescale 1ns/10ps
`include "hssb_defines.vh"
module hw_single_step_breakpoint_bench;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [5:0]  awaddr = 6'h0, araddr = 6'h0;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h52;
  logic [3:0]  btn = 4'h0;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, ready, led, ale, opf, mrd, mwr;
  logic [15:0] addr;
  logic        en = 1'h0, every = 1'h0, armed = 1'h0;
  int          err_count = 0, cmp_count = 0, stp = 0;

  always #20 aclk = ~aclk;

  hssb_top i_hssb_top (
    .aclk(aclk), .aresetn(aresetn), .ce(1'h1),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .step_enable_button(btn[`HSSB_BTN_ENABLE]),
    .every_cycle_mode_button(btn[`HSSB_BTN_EVERY]),
    .opcode_fetch_mode_button(btn[`HSSB_BTN_OPCODE]),
    .step_advance_button(btn[`HSSB_BTN_ADVANCE]), .cpu_ale(ale), .cpu_addr(addr),
    .cpu_opfetch(opf), .cpu_mem_rd(mrd), .cpu_mem_wr(mwr), .cpu_ready(ready),
    .step_enabled_led(led)
  );

  hssb_cpu_model i_hssb_cpu_model (
    .aclk(aclk), .cpu_ready(ready), .cpu_ale(ale), .cpu_addr(addr),
    .cpu_opfetch(opf), .cpu_mem_rd(mrd), .cpu_mem_wr(mwr)
  );

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  function automatic logic [31:0] status_exp();
    return {28'h0, 1'h0, armed, every, en};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] i, input logic [31:0] d, input logic [1:0] er);
    logic ga, gw, da, dw;
    da = 1'h0;
    dw = 1'h0;
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge aclk);
      ga = awvalid & awready;
      gw = wvalid & wready;
      @(posedge aclk);
      if (ga) awvalid <= 1'h0;
      if (gw) wvalid <= 1'h0;
      da |= ga;
      dw |= gw;
    end while (!(da && dw));
    do begin
      @(negedge aclk);
      ga = bvalid;
      dw = (bresp === er);
      @(posedge aclk);
    end while (!ga);
    bready <= 1'h0;
    chk(dw, 1'h1);
  endtask

  task automatic rd_chk(input logic [3:0] i, input logic [31:0] ed, input logic [1:0] er);
    logic g;
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge aclk);
      g = arready;
      @(posedge aclk);
    end while (!g);
    arvalid <= 1'h0;
    do begin
      @(negedge aclk);
      g = rvalid;
      if (g) chk({rresp, rdata}, {er, ed});
      @(posedge aclk);
    end while (!g);
    rready <= 1'h0;
  endtask

  // held long enough that the press pulse lands while the pin is still high
  task automatic press(input int b);
    @(posedge aclk);
    btn[b] <= 1'h1;
    repeat (6) @(posedge aclk);
    btn[b] <= 1'h0;
    repeat (6) @(posedge aclk);
  endtask

  task automatic cyc(input logic [15:0] a, input int k, input int b, input logic held);
    int w;
    fork
      i_hssb_cpu_model.bus_cycle(a, k, w);
      begin
        repeat (14) @(posedge aclk);
        press(b);
      end
    join
    chk(w != 0, held);
    // only an advance press out of a hold counts as a released step
    if (held && b == `HSSB_BTN_ADVANCE) stp++;
  endtask

  initial begin
    logic [15:0] t;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    chk({led, ready}, 2'h1);
    rd_chk(`HSSB_IDX_STATUS, status_exp(), `HSSB_RESP_OKAY);
    for (int k = 0; k < 4; k++) cyc(rnd(), k, `HSSB_BTN_ADVANCE, 1'h0);
    $display("test free run done");
    press(`HSSB_BTN_ENABLE);
    en = 1'h1;
    chk(led, en);
    for (int k = 0; k < 4; k++) cyc(rnd(), k, `HSSB_BTN_ADVANCE, k == 0);
    press(`HSSB_BTN_EVERY);
    every = 1'h1;
    rd_chk(`HSSB_IDX_STATUS, status_exp(), `HSSB_RESP_OKAY);
    for (int k = 0; k < 4; k++) cyc(rnd(), k, `HSSB_BTN_ADVANCE, k != 3);
    cyc(rnd(), 0, `HSSB_BTN_ENABLE, 1'h1);
    en = 1'h0;
    chk(led, en);
    $display("test stepping done");
    for (int i = 0; i < 3; i++) rd_chk(i, 32'h0, `HSSB_RESP_OKAY);
    t = rnd();
    rd_chk(4'h6 + {1'h0, t[2:0]}, 32'h0, `HSSB_RESP_SLVERR);
    axi_wr(4'h6 + {1'h0, t[5:3]}, {16'h0, t}, `HSSB_RESP_SLVERR);
    for (int n = 0; n < 2; n++) begin
      t = n ? rnd() : 16'hFFFF;
      axi_wr(`HSSB_IDX_LOW, {rnd(), 8'h0, t[7:0]}, `HSSB_RESP_OKAY);
      axi_wr(`HSSB_IDX_HIGH, {rnd(), 8'h0, t[15:8]}, `HSSB_RESP_OKAY);
      axi_wr(`HSSB_IDX_ARM, {16'h0, rnd()}, `HSSB_RESP_OKAY);
      armed = 1'h1;
      rd_chk(`HSSB_IDX_STATUS, status_exp(), `HSSB_RESP_OKAY);
      cyc(t ^ 16'h0001, 2, `HSSB_BTN_ADVANCE, 1'h0);
      cyc(t ^ 16'h8000, 1, `HSSB_BTN_ADVANCE, 1'h0);
      cyc(t, 2 - n, `HSSB_BTN_ADVANCE, 1'h1);
      en = 1'h1;
      armed = 1'h0;
      rd_chk(`HSSB_IDX_STATUS, status_exp(), `HSSB_RESP_OKAY);
      rd_chk(`HSSB_IDX_HELD, {16'h0, t}, `HSSB_RESP_OKAY);
      press(`HSSB_BTN_ENABLE);
      en = 1'h0;
      cyc(t, n, `HSSB_BTN_ADVANCE, 1'h0);
    end
    $display("test breakpoint done");
    press(`HSSB_BTN_OPCODE);
    every = 1'h0;
    rd_chk(`HSSB_IDX_STATUS, status_exp(), `HSSB_RESP_OKAY);
    rd_chk(`HSSB_IDX_STEPS, stp, `HSSB_RESP_OKAY);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    $display("Error at %0t ns: watchdog %h expected %h", $time, 1'h1, 1'h0);
    complete_run();
  end
endmodule
